// File: rtl/wrs_params.svh
`ifndef WRS_PARAMS_SVH
`define WRS_PARAMS_SVH
// register indices; the AXI4-Lite byte address is four times the index,
// since the printed offsets are not all word aligned
`define WRS_OFF_SLICE_A     8'hd6
`define WRS_OFF_SLICE_B     8'hd7
`define WRS_OFF_SP_HIGH     8'hd8
`define WRS_OFF_SP_LOW      8'hd9
// reset values of the slice pointers: common area c0h-cfh
`define WRS_RST_SLICE_A     8'hc0
`define WRS_RST_SLICE_B     8'hc8
// 8-bit working register prefix in the upper nibble
`define WRS_WREG_PREFIX     4'hc
// axi response codes
`define WRS_RESP_OKAY       2'b00
`define WRS_RESP_SLVERR     2'b10
`endif

// File: rtl/wrs_pkg.sv
package wrs_pkg;
   // stack operation requested by the execution unit
   typedef enum logic [2:0] {
      WRS_OP_NONE,
      WRS_OP_PUSH,
      WRS_OP_POP,
      WRS_OP_USER_PUSH_DECR,
      WRS_OP_USER_PUSH_INCR,
      WRS_OP_USER_POP_DECR,
      WRS_OP_USER_POP_INCR
   } wrs_stack_op_e;
   typedef logic [7:0] wrs_byte_t;
endpackage

// File: rtl/wrs_working_reg_stack.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "wrs_params.svh"

// What this block does
// - 4-bit operand msb picks slice pointer: 0 first, 1 second.
// - upper five pointer bits become upper five address bits.
// - operand low three bits become address low three bits.
// - 8-bit operand with upper nibble 1100b is decoded as 4-bit form.
// - in the 8-bit form bit 3 picks pointer, bits 2-0 give low bits.
// - stack pointer drops by one before push, rises by one after pop.
// - stack pointer always holds the address of the top byte.
// - call pushes program counter; return pops it back.
// - interrupt pushes program counter and flags; interrupt return pops both.
// - 16-bit stack pointer: high byte at d8h, low byte at d9h.
// - stack pointer has no defined value after reset.
// - low byte wrap carries or borrows into the high byte.
// - user stacks push and pop anywhere with pre or post adjusted pointer.
// - the two slice pointers are read-write registers at d6h and d7h.
// - at reset the pointers select common area c0h-c7h and c8h-cfh.
module wrs_working_reg_stack
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write address and data
   input  wire logic [9:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read
   input  wire logic [9:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // working register operand decode
   input  wire logic [7:0]            operand,
   input  wire logic                  operand_is_short,
   output logic [7:0]                 reg_addr,
   output logic                       operand_is_working,
   // stack operations from the execution unit
   input  wire wrs_pkg::wrs_stack_op_e stack_op,
   input  wire logic [7:0]            user_stack_ptr,
   output logic [7:0]                 stack_access_addr,
   output logic [7:0]                 user_stack_ptr_next,
   output logic [15:0]                stack_pointer
);
   import wrs_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]  slice_pointer_a_q;
   logic [7:0]  slice_pointer_b_q;
   logic [15:0] stack_pointer_q;
   logic [15:0] stack_pointer_d;
   logic        aw_held_q;
   logic        w_held_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        wr_fire;
   logic        wr_hit;
   logic        rd_fire;
   logic        sp_high_loaded_q;
   logic        sp_low_loaded_q;
   logic        sp_loaded;

   // ---------------------------------------------------------------
   // working register address formation
   // ---------------------------------------------------------------
   // pick pointer by the nibble msb and join pointer top with low bits
   function automatic logic [7:0] wreg_addr(input logic [3:0] nib, input logic [7:0] pa,
                                            input logic [7:0] pb);
      logic [7:0] ptr;
      ptr = nib[3] ? pb : pa;
      return {ptr[7:3], nib[2:0]};
   endfunction

   // purely combinational so a pointer write counts from the next decode
   always_comb
   begin
      operand_is_working = operand_is_short || (operand[7:4] == `WRS_WREG_PREFIX);
      if (operand_is_working)
         reg_addr = wreg_addr(operand[3:0], slice_pointer_a_q, slice_pointer_b_q);
      else
         reg_addr = operand;
   end

   // ---------------------------------------------------------------
   // stack pointer arithmetic
   // ---------------------------------------------------------------
   // push pre-decrements, pop post-increments; full 16-bit carry
   always_comb
   begin
      stack_pointer_d     = stack_pointer_q;
      stack_access_addr   = stack_pointer_q[7:0];
      user_stack_ptr_next = user_stack_ptr;
      unique case (stack_op)
         WRS_OP_PUSH:
         begin
            stack_pointer_d   = stack_pointer_q - 16'h0001;
            stack_access_addr = stack_pointer_d[7:0];
         end
         WRS_OP_POP:
         begin
            stack_pointer_d   = stack_pointer_q + 16'h0001;
            stack_access_addr = stack_pointer_q[7:0];
         end
         WRS_OP_USER_PUSH_DECR:
         begin
            user_stack_ptr_next = user_stack_ptr - 8'h01;
            stack_access_addr   = user_stack_ptr_next;
         end
         WRS_OP_USER_PUSH_INCR:
         begin
            user_stack_ptr_next = user_stack_ptr + 8'h01;
            stack_access_addr   = user_stack_ptr_next;
         end
         WRS_OP_USER_POP_DECR:
         begin
            user_stack_ptr_next = user_stack_ptr - 8'h01;
            stack_access_addr   = user_stack_ptr;
         end
         WRS_OP_USER_POP_INCR:
         begin
            user_stack_ptr_next = user_stack_ptr + 8'h01;
            stack_access_addr   = user_stack_ptr;
         end
         default:
         begin
            stack_pointer_d = stack_pointer_q;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // axi4-lite write path
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_hit        = (aw_addr_q == `WRS_OFF_SLICE_A) || (aw_addr_q == `WRS_OFF_SLICE_B) ||
                          (aw_addr_q == `WRS_OFF_SP_HIGH) || (aw_addr_q == `WRS_OFF_SP_LOW);

   // hold address and data apart so either may come first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[9:2];          // word index
         end
         else if (wr_fire)
            aw_held_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held_q <= 1'b0;
      end
   end

   // write response, slverr on an unmapped word
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WRS_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `WRS_RESP_OKAY : `WRS_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ---------------------------------------------------------------
   // slice pointers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slice_pointer_a_q <= `WRS_RST_SLICE_A;
         slice_pointer_b_q <= `WRS_RST_SLICE_B;
      end
      else if (wr_fire && w_strb_q[0])
      begin
         if (aw_addr_q == `WRS_OFF_SLICE_A)
            slice_pointer_a_q <= w_data_q[7:0];
         if (aw_addr_q == `WRS_OFF_SLICE_B)
            slice_pointer_b_q <= w_data_q[7:0];
      end
   end

   // ---------------------------------------------------------------
   // stack pointer register
   // ---------------------------------------------------------------
   // no reset on purpose: contents are undefined until software loads them;
   // a bus write in the same cycle as a stack op wins for the written byte
   always_ff @(posedge aclk)
   begin
      stack_pointer_q <= stack_pointer_d;
      if (wr_fire && w_strb_q[0] && (aw_addr_q == `WRS_OFF_SP_HIGH))
         stack_pointer_q[15:8] <= w_data_q[7:0];
      if (wr_fire && w_strb_q[0] && (aw_addr_q == `WRS_OFF_SP_LOW))
         stack_pointer_q[7:0] <= w_data_q[7:0];
   end
   assign stack_pointer = stack_pointer_q;

   // ---------------------------------------------------------------
   // stack pointer load tracking
   // ---------------------------------------------------------------
   // the pointer has no reset, so its checks wait until software has
   // loaded both bytes; before that its value means nothing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sp_high_loaded_q <= 1'b0;
         sp_low_loaded_q  <= 1'b0;
      end
      else if (wr_fire && w_strb_q[0])
      begin
         if (aw_addr_q == `WRS_OFF_SP_HIGH)
            sp_high_loaded_q <= 1'b1;
         if (aw_addr_q == `WRS_OFF_SP_LOW)
            sp_low_loaded_q <= 1'b1;
      end
   end
   assign sp_loaded = sp_high_loaded_q && sp_low_loaded_q;

   // ---------------------------------------------------------------
   // axi4-lite read path
   // ---------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `WRS_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `WRS_RESP_OKAY;
         unique case (s_axi_araddr[9:2])
            `WRS_OFF_SLICE_A: s_axi_rdata <= {24'h0, slice_pointer_a_q};
            `WRS_OFF_SLICE_B: s_axi_rdata <= {24'h0, slice_pointer_b_q};
            `WRS_OFF_SP_HIGH: s_axi_rdata <= {24'h0, stack_pointer_q[15:8]};
            `WRS_OFF_SP_LOW:  s_axi_rdata <= {24'h0, stack_pointer_q[7:0]};
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `WRS_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pointer_pick_a: assert property (operand_is_short |->
      reg_addr[7:3] == (operand[3] ? slice_pointer_b_q[7:3] : slice_pointer_a_q[7:3]))
      else $error("wrong slice pointer chosen");
   low_bits_a: assert property (operand_is_working |-> reg_addr[2:0] == operand[2:0])
      else $error("low address bits not from operand");
   long_form_a: assert property ((!operand_is_short && operand[7:4] == 4'hc) |-> operand_is_working)
      else $error("1100b prefix not decoded");
   direct_form_a: assert property ((!operand_is_short && operand[7:4] != 4'hc) |-> reg_addr == operand)
      else $error("direct address altered");
   push_dec_a: assert property (sp_loaded && stack_op == WRS_OP_PUSH && !wr_fire |=>
      stack_pointer == $past(stack_pointer) - 16'h0001)
      else $error("push did not decrement");
   pop_inc_a: assert property (sp_loaded && stack_op == WRS_OP_POP && !wr_fire |=>
      stack_pointer == $past(stack_pointer) + 16'h0001)
      else $error("pop did not increment");
   push_addr_a: assert property (sp_loaded && stack_op == WRS_OP_PUSH && !wr_fire |=>
      stack_pointer[7:0] == $past(stack_access_addr))
      else $error("push address not the new top");
   ptr_write_a: assert property (wr_fire && w_strb_q[0] && aw_addr_q == 8'hd6 |=>
      slice_pointer_a_q == $past(w_data_q[7:0]))
      else $error("slice pointer write lost");
   idle_hold_a: assert property (sp_loaded && stack_op == WRS_OP_NONE && !wr_fire |=> $stable(stack_pointer))
      else $error("stack pointer moved while idle");
   pop_addr_a: assert property (sp_loaded && stack_op == WRS_OP_POP |->
      stack_access_addr == stack_pointer[7:0])
      else $error("pop address not the old top");
   user_push_a: assert property (stack_op == WRS_OP_USER_PUSH_DECR |->
      stack_access_addr == user_stack_ptr - 8'h01 && user_stack_ptr_next == user_stack_ptr - 8'h01)
      else $error("user push address not pre-decremented");
   user_pop_a: assert property (stack_op == WRS_OP_USER_POP_INCR |->
      stack_access_addr == user_stack_ptr && user_stack_ptr_next == user_stack_ptr + 8'h01)
      else $error("user pop address not the old pointer");
   slice_b_write_a: assert property (wr_fire && w_strb_q[0] && aw_addr_q == `WRS_OFF_SLICE_B |=>
      slice_pointer_b_q == $past(w_data_q[7:0]))
      else $error("second slice pointer write lost");
   sp_low_write_a: assert property (wr_fire && w_strb_q[0] && aw_addr_q == `WRS_OFF_SP_LOW |=>
      stack_pointer[7:0] == $past(w_data_q[7:0]))
      else $error("stack pointer low byte write lost");
   reset_ptr_a: assert property (disable iff (1'b0) (!aresetn |=>
      slice_pointer_a_q == `WRS_RST_SLICE_A && slice_pointer_b_q == `WRS_RST_SLICE_B))
      else $error("slice pointers not at common area after reset");
   bresp_wait_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");

   push_seen_c: cover property (stack_op == WRS_OP_PUSH ##1 stack_op == WRS_OP_POP);
   wrap_seen_c: cover property (stack_op == WRS_OP_POP && stack_pointer[7:0] == 8'hff);
   long_op_c:   cover property (!operand_is_short && operand_is_working);
   write_c:     cover property (wr_fire && aw_addr_q == 8'hd7);
   user_op_c:   cover property (stack_op == WRS_OP_USER_POP_INCR);

endmodule // wrs_working_reg_stack

// File: verification/wrs_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// core side: decoder and execution unit seen by the block
// ----------------------------------------------------------------
module wrs_core_model
(
   // clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // instructions issued by the bench
   input  wire wrs_pkg::wrs_stack_op_e cmd_op,
   input  wire logic [7:0]             cmd_operand,
   input  wire logic                   cmd_short,
   input  wire logic                   cmd_load,
   input  wire logic [7:0]             cmd_value,
   // towards the block
   output wrs_pkg::wrs_stack_op_e      stack_op,
   output logic [7:0]                  operand,
   output logic                        operand_is_short,
   output logic [7:0]                  user_stack_ptr,
   input  wire logic [7:0]             user_stack_ptr_next
);
   import wrs_pkg::*;
   logic [7:0] uptr_q;
   // decoder fields follow the instruction in execution
   assign stack_op         = cmd_op;
   assign operand          = cmd_operand;
   assign operand_is_short = cmd_short;
   assign user_stack_ptr   = uptr_q;
   // the core owns the user pointer and writes back only on user ops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         uptr_q <= 8'h00;
      else if (cmd_load)
         uptr_q <= cmd_value;
      else if (cmd_op >= WRS_OP_USER_PUSH_DECR)
         uptr_q <= user_stack_ptr_next;
   end
endmodule // wrs_core_model

// File: verification/tb_working_reg_addr_and_stack.sv
`timescale 1ns/1ps
`include "wrs_params.svh"
// ----------------------------------------------------------------
// bench for working register decode and stack pointer
// ----------------------------------------------------------------
module tb_working_reg_addr_and_stack;
   import wrs_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
   logic [9:0] awaddr, araddr;
   logic [7:0] reg_addr, sacc, unext, uptr, operand, cmd_operand, cmd_value;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, r;
   logic [15:0] sp;
   logic is_work, is_short, cmd_short, cmd_load;
   wrs_stack_op_e cmd_op, stack_op;
   int failures = 0;
   int checks = 0;
   logic [31:0] d;
   // clock at 100 MHz
   initial
   begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   wrs_working_reg_stack dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .operand(operand),
      .operand_is_short(is_short), .reg_addr(reg_addr), .operand_is_working(is_work), .stack_op(stack_op),
      .user_stack_ptr(uptr), .stack_access_addr(sacc), .user_stack_ptr_next(unext), .stack_pointer(sp));
   wrs_core_model core (.aclk(aclk), .aresetn(aresetn), .cmd_op(cmd_op), .cmd_operand(cmd_operand),
      .cmd_short(cmd_short), .cmd_load(cmd_load), .cmd_value(cmd_value), .stack_op(stack_op),
      .operand(operand), .operand_is_short(is_short), .user_stack_ptr(uptr), .user_stack_ptr_next(unext));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_sim;
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one write; ready is judged on values settled 1 ns after each edge
   task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
      logic at, wt, bt;
      @(posedge aclk);
      awaddr <= {a, 2'b00}; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
      bt = 0;
      for (int n = 0; n < 50 && !bt; n++)
      begin
         #1;
         at = awvalid && awready; wt = wvalid && wready; bt = bvalid; rsp = bresp;
         @(posedge aclk);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
         if (bt) bready <= 1'b0;
      end
      if (!bt) chk(1'b0, 1'b1);
   endtask
   task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
      logic at, rt;
      @(posedge aclk);
      araddr <= {a, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
      rt = 0;
      for (int n = 0; n < 50 && !rt; n++)
      begin
         #1;
         at = arvalid && arready; rt = rvalid; v = rdata; rsp = rresp;
         @(posedge aclk);
         if (at) arvalid <= 1'b0;
         if (rt) rready <= 1'b0;
      end
      if (!rt) chk(1'b0, 1'b1);
   endtask
   task dec(input logic s, input logic [7:0] o, input logic w, input logic [7:0] ea);
      @(posedge aclk);
      cmd_short <= s; cmd_operand <= o;
      #1 chk(is_work, w);
      chk(reg_addr, ea);
   endtask
   // stack op: address seen in the op cycle, pointer after its edge
   task stk(input wrs_stack_op_e op, input logic [7:0] ea, input logic [15:0] es);
      @(posedge aclk);
      cmd_op <= op;
      #1 chk(sacc, ea);
      @(posedge aclk);
      cmd_op <= WRS_OP_NONE;
      #1 chk(sp, es);
   endtask
   task uop(input wrs_stack_op_e op, input logic [7:0] ea, input logic [7:0] en);
      @(posedge aclk);
      cmd_load <= 1'b1; cmd_value <= 8'h40;
      @(posedge aclk);
      cmd_load <= 1'b0; cmd_op <= op;
      #1 chk(sacc, ea);
      chk(unext, en);
      @(posedge aclk);
      cmd_op <= WRS_OP_NONE;
      #1 chk(uptr, en);
   endtask
   task t_reset_decode;
      dec(1'b1, 8'h03, 1'b1, 8'hc3);
      dec(1'b1, 8'h0b, 1'b1, 8'hcb);
      axr(`WRS_OFF_SLICE_A, d, r); chk(d, 32'hc0);
      axr(`WRS_OFF_SLICE_B, d, r); chk(d, 32'hc8);
   endtask
   task t_pointer_decode;
      axw(`WRS_OFF_SLICE_A, 32'h77, r);
      axw(`WRS_OFF_SLICE_B, 32'ha8, r);
      dec(1'b1, 8'h06, 1'b1, 8'h76);
      dec(1'b1, 8'h0f, 1'b1, 8'haf);
      dec(1'b0, 8'hcb, 1'b1, 8'hab);
      dec(1'b0, 8'hc2, 1'b1, 8'h72);
      dec(1'b0, 8'hdb, 1'b0, 8'hdb);
   endtask
   task t_system_stack;
      axw(`WRS_OFF_SP_HIGH, 32'h12, r); chk(r, `WRS_RESP_OKAY);
      axw(`WRS_OFF_SP_LOW, 32'hff, r);
      #1 chk(sp, 16'h12ff);
      stk(WRS_OP_PUSH, 8'hfe, 16'h12fe);
      stk(WRS_OP_PUSH, 8'hfd, 16'h12fd);
      stk(WRS_OP_PUSH, 8'hfc, 16'h12fc);
      stk(WRS_OP_POP, 8'hfc, 16'h12fd);
      stk(WRS_OP_POP, 8'hfd, 16'h12fe);
      stk(WRS_OP_POP, 8'hfe, 16'h12ff);
      axw(`WRS_OFF_SP_LOW, 32'h00, r);
      stk(WRS_OP_PUSH, 8'hff, 16'h11ff);
      stk(WRS_OP_POP, 8'hff, 16'h1200);
      axr(`WRS_OFF_SP_HIGH, d, r); chk(d, 32'h12);
      axr(`WRS_OFF_SP_LOW, d, r); chk(d, 32'h00);
   endtask
   task t_user_and_unmapped;
      uop(WRS_OP_USER_PUSH_DECR, 8'h3f, 8'h3f);
      uop(WRS_OP_USER_PUSH_INCR, 8'h41, 8'h41);
      uop(WRS_OP_USER_POP_DECR, 8'h40, 8'h3f);
      uop(WRS_OP_USER_POP_INCR, 8'h40, 8'h41);
      axw(8'h10, 32'h55, r); chk(r, `WRS_RESP_SLVERR);
      axr(8'h10, d, r); chk(r, `WRS_RESP_SLVERR);
   endtask
   // main sequence: two cycles of reset, then the scenarios
   initial
   begin
      aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; cmd_op = WRS_OP_NONE; cmd_operand = 0;
      cmd_short = 0; cmd_load = 0; cmd_value = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_decode;
      t_pointer_decode;
      t_system_stack;
      t_user_and_unmapped;
      end_sim;
   end
   // watchdog well beyond the fewer than one hundred cycles the scenarios need
   initial
   begin
      #100000;
      failures++;
      end_sim;
   end
endmodule // tb_working_reg_addr_and_stack
